/* hdl/pctl_irq_ctrl.sv */
// Peripheral interrupt enable, priority and routing with APB register access
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pctl_map.svh"

module pctl_irq_ctrl (
    // Clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata_ff,
    output logic                         pready_ff,
    output logic                         pslverr_ff,
    // Peripheral flag levels, same clock
    input  wire logic [7:0]              periph_flags_one,
    input  wire logic [4:0]              periph_flags_two,
    input  wire logic [4:0]              reset_cause_flags,
    input  wire logic [15:0]             timer_zero_count,
    // Asynchronous pins
    input  wire pctl_pkg::pctl_pins_s    pins,
    // Processor core
    input  wire logic                    core_sleeping,
    input  wire logic                    irq_enter,
    input  wire logic                    ret_pop,
    input  wire logic [`PCTL_PC_W-1:0]   ret_pc,
    input  wire pctl_pkg::pctl_ctx_s     ctx_in,
    output logic                         irq_high_ff,
    output logic                         irq_low_ff,
    output logic                         wake_ff,
    output pctl_pkg::pctl_ctx_s          fast_ctx_ff,
    output logic      [`PCTL_PC_W-1:0]   ret_pc_ff
);
    import pctl_pkg::*;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Hardware set beats a simultaneous software clear
    function automatic logic flag_nxt(input logic cur, input logic set,
                                      input logic wr, input logic wbit);
        flag_nxt = set | (wr ? wbit : cur);
    endfunction

    // Offset decode, shared by read mux and write strobes
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    pctl_bus_e   bus_ff;
    logic [7:0]  en_one_ff;
    logic [4:0]  en_two_ff;
    logic [7:0]  prio_one_ff;
    logic [4:0]  prio_two_ff;
    logic        prio_lvl_ff;
    logic [7:0]  main_ctl_ff;
    logic [7:0]  ctl_two_ff;
    logic [7:0]  ctl_three_ff;
    logic        t0_mode16_ff;
    logic [15:0] t0_prev_ff;
    logic        t0_primed_ff;
    logic [6:0]  sync1_ff;
    logic [6:0]  sync2_ff;
    logic [6:0]  sync3_ff;
    logic [6:0]  stable_ff;
    logic [3:0]  primed_ff;
    logic        stack_full;
    logic [31:0] nxt_rdata;
    logic        nxt_err;
    logic        wr_en;
    logic        wr_main;
    logic        wr_three;
    logic [7:0]  wd;
    logic [6:0]  pin_change;
    logic [2:0]  ext_event;
    logic        pb_event;
    logic        t0_event;
    logic [17:0] req;
    logic [17:0] prio;
    logic [17:0] group;
    logic        nxt_high;
    logic        nxt_low;

    assign wd = pwdata[7:0];
    // Writes land only at the completing access edge
    assign wr_en = psel && penable && pwrite && pready_ff;
    assign wr_main  = wr_en && hit(paddr, `PCTL_OFF_MAIN_CTL);
    assign wr_three = wr_en && hit(paddr, `PCTL_OFF_CTL_THREE);

    // ------------------------------------------------------------
    // APB slave: one setup, one access cycle, no wait states
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_ff    <= PCTL_BUS_IDLE;
            pready_ff <= 1'b0;
        end else begin
            case (bus_ff)
                PCTL_BUS_IDLE: begin
                    if (psel && !penable) begin
                        bus_ff    <= PCTL_BUS_ACCESS;
                        pready_ff <= 1'b1;
                    end
                end
                PCTL_BUS_ACCESS: begin
                    bus_ff    <= PCTL_BUS_IDLE;
                    pready_ff <= 1'b0;
                end
                default: begin
                    bus_ff    <= PCTL_BUS_IDLE;
                    pready_ff <= 1'b0;
                end
            endcase
        end
    end

    // Read mux; unimplemented bits read zero, unmapped offsets error
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_err   = 1'b0;
        if (hit(paddr, `PCTL_OFF_EN_ONE)) begin
            nxt_rdata[7:0] = en_one_ff;
        end else if (hit(paddr, `PCTL_OFF_EN_TWO)) begin
            nxt_rdata[4:0] = en_two_ff;
        end else if (hit(paddr, `PCTL_OFF_PRIO_ONE)) begin
            nxt_rdata[7:0] = prio_one_ff;
        end else if (hit(paddr, `PCTL_OFF_PRIO_TWO)) begin
            nxt_rdata[4:0] = prio_two_ff;
        end else if (hit(paddr, `PCTL_OFF_RST_CTL)) begin
            nxt_rdata[7:0] = {prio_lvl_ff, 2'b00, reset_cause_flags};
        end else if (hit(paddr, `PCTL_OFF_MAIN_CTL)) begin
            nxt_rdata[7:0] = main_ctl_ff;
        end else if (hit(paddr, `PCTL_OFF_CTL_TWO)) begin
            nxt_rdata[7:0] = ctl_two_ff;
        end else if (hit(paddr, `PCTL_OFF_CTL_THREE)) begin
            nxt_rdata[7:0] = ctl_three_ff;
        end else if (hit(paddr, `PCTL_OFF_TMR_MODE)) begin
            nxt_rdata[0] = t0_mode16_ff;
        end else if (hit(paddr, `PCTL_OFF_STATUS)) begin
            nxt_rdata[3:0] = {stack_full, wake_ff, irq_low_ff, irq_high_ff};
        end else begin
            nxt_err = 1'b1;
        end
    end

    // Read data and error captured in setup, shown during access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (psel && !penable) begin
            prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_rdata;
            pslverr_ff <= nxt_err;
        end else begin
            pslverr_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Peripheral enable and priority registers
    // ------------------------------------------------------------
    // enable one, reset zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_one_ff <= `PCTL_RST_EN;
        end else if (wr_en && hit(paddr, `PCTL_OFF_EN_ONE)) begin
            en_one_ff <= wd;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_two_ff <= 5'(`PCTL_RST_EN);
        end else if (wr_en && hit(paddr, `PCTL_OFF_EN_TWO)) begin
            en_two_ff <= wd[4:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prio_one_ff <= `PCTL_RST_PRIO_ONE;
        end else if (wr_en && hit(paddr, `PCTL_OFF_PRIO_ONE)) begin
            prio_one_ff <= wd;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prio_two_ff <= 5'(`PCTL_RST_PRIO_TWO);
        end else if (wr_en && hit(paddr, `PCTL_OFF_PRIO_TWO)) begin
            prio_two_ff <= wd[4:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prio_lvl_ff <= 1'b0;
        end else if (wr_en && hit(paddr, `PCTL_OFF_RST_CTL)) begin
            prio_lvl_ff <= wd[`PCTL_RC_PRIO_LVL];
        end
    end

    // Timer zero width: 8-bit by default
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t0_mode16_ff <= 1'b0;
        end else if (wr_en && hit(paddr, `PCTL_OFF_TMR_MODE)) begin
            t0_mode16_ff <= wd[0];
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers and change qualification
    // ------------------------------------------------------------
    // three flops, change accepted when stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_ff[gi]  <= 1'b0;
                    sync2_ff[gi]  <= 1'b0;
                    sync3_ff[gi]  <= 1'b0;
                    stable_ff[gi] <= 1'b0;
                end else begin
                    sync1_ff[gi] <= pins[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                    sync3_ff[gi] <= sync2_ff[gi];
                    if (sync2_ff[gi] == sync3_ff[gi]) begin
                        stable_ff[gi] <= sync3_ff[gi];
                    end
                end
            end
            // First agreed level after reset is taken silently
            assign pin_change[gi] = primed_ff[3] && (sync2_ff[gi] == sync3_ff[gi])
                                    && (sync3_ff[gi] != stable_ff[gi]);
        end
    endgenerate

    // Priming waits for the pipeline to fill so reset levels make no event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primed_ff <= 4'h0;
        end else begin
            primed_ff <= {primed_ff[2:0], 1'b1};
        end
    end

    // edge select picks rising or falling per pin
    assign ext_event[0] = pin_change[0] && (sync3_ff[0] == ctl_two_ff[`PCTL_C2_EDGE0]);
    assign ext_event[1] = pin_change[1] && (sync3_ff[1] == ctl_two_ff[`PCTL_C2_EDGE1]);
    assign ext_event[2] = pin_change[2] && (sync3_ff[2] == ctl_two_ff[`PCTL_C2_EDGE2]);
    // any change on the upper port nibble
    assign pb_event = |pin_change[6:3];

    // ------------------------------------------------------------
    // Timer zero roll-over
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t0_prev_ff   <= 16'h0000;
            t0_primed_ff <= 1'b0;
        end else begin
            t0_prev_ff   <= timer_zero_count;
            t0_primed_ff <= 1'b1;
        end
    end

    // FFh to 00h in 8-bit mode, FFFFh to 0000h in 16-bit mode
    assign t0_event = t0_primed_ff && (t0_mode16_ff ?
        (t0_prev_ff == `PCTL_T0_MAX16 && timer_zero_count == 16'h0000) :
        (t0_prev_ff[7:0] == `PCTL_T0_MAX8 && timer_zero_count[7:0] == 8'h00));

    // ------------------------------------------------------------
    // Control registers holding core-side flags
    // ------------------------------------------------------------
    // flags set whatever the enables; edge sets flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_ctl_ff <= `PCTL_RST_MAIN;
        end else begin
            main_ctl_ff[7:3] <= wr_main ? wd[7:3] : main_ctl_ff[7:3];
            main_ctl_ff[`PCTL_MC_T0_FLAG] <= flag_nxt(main_ctl_ff[`PCTL_MC_T0_FLAG],
                t0_event, wr_main, wd[`PCTL_MC_T0_FLAG]);
            main_ctl_ff[`PCTL_MC_X0_FLAG] <= flag_nxt(main_ctl_ff[`PCTL_MC_X0_FLAG],
                ext_event[0], wr_main, wd[`PCTL_MC_X0_FLAG]);
            main_ctl_ff[`PCTL_MC_PB_FLAG] <= flag_nxt(main_ctl_ff[`PCTL_MC_PB_FLAG],
                pb_event, wr_main, wd[`PCTL_MC_PB_FLAG]);
        end
    end

    // Edge selects and timer/port priorities; bits 3 and 1 unimplemented
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_two_ff <= `PCTL_RST_CTL_TWO;
        end else if (wr_en && hit(paddr, `PCTL_OFF_CTL_TWO)) begin
            ctl_two_ff <= wd & `PCTL_MASK_CTL_TWO;
        end
    end

    // flags stay until software clears them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_three_ff <= `PCTL_RST_CTL_THREE;
        end else begin
            ctl_three_ff[7:2] <= wr_three ? (wd[7:2] & 6'(`PCTL_MASK_CTL_THR >> 2))
                                          : ctl_three_ff[7:2];
            ctl_three_ff[`PCTL_C3_X2_FLAG] <= flag_nxt(ctl_three_ff[`PCTL_C3_X2_FLAG],
                ext_event[2], wr_three, wd[`PCTL_C3_X2_FLAG]);
            ctl_three_ff[`PCTL_C3_X1_FLAG] <= flag_nxt(ctl_three_ff[`PCTL_C3_X1_FLAG],
                ext_event[1], wr_three, wd[`PCTL_C3_X1_FLAG]);
        end
    end

    // ------------------------------------------------------------
    // Request forming and routing
    // ------------------------------------------------------------
    // flag AND enable per source; core-source gates
    assign req = {periph_flags_one & en_one_ff,
                  periph_flags_two & en_two_ff,
                  main_ctl_ff[`PCTL_MC_X0_FLAG] & main_ctl_ff[`PCTL_MC_X0_EN],
                  ctl_three_ff[`PCTL_C3_X1_FLAG] & ctl_three_ff[`PCTL_C3_X1_EN],
                  ctl_three_ff[`PCTL_C3_X2_FLAG] & ctl_three_ff[`PCTL_C3_X2_EN],
                  main_ctl_ff[`PCTL_MC_T0_FLAG] & main_ctl_ff[`PCTL_MC_T0_EN],
                  main_ctl_ff[`PCTL_MC_PB_FLAG] & main_ctl_ff[`PCTL_MC_PB_EN]};
    // external zero is always high priority
    assign prio = {prio_one_ff, prio_two_ff, 1'b1,
                   ctl_three_ff[`PCTL_C3_X1_PRIO], ctl_three_ff[`PCTL_C3_X2_PRIO],
                   ctl_two_ff[`PCTL_C2_T0_PRIO], ctl_two_ff[`PCTL_C2_PB_PRIO]};
    // Peripheral sources sit behind the group enable in legacy mode
    assign group = {13'h1fff, 5'h00};

    // priorities only matter with levels on; group gate in legacy
    always_comb begin
        nxt_high = 1'b0;
        nxt_low  = 1'b0;
        if (prio_lvl_ff) begin
            nxt_high = main_ctl_ff[`PCTL_MC_GLOBAL] && |(req & prio);
            // Low level also needs the second enable, held in the group bit
            nxt_low  = main_ctl_ff[`PCTL_MC_GLOBAL] && main_ctl_ff[`PCTL_MC_GROUP]
                       && |(req & ~prio);
        end else begin
            nxt_high = main_ctl_ff[`PCTL_MC_GLOBAL] &&
                       (|(req & ~group) || (main_ctl_ff[`PCTL_MC_GROUP] && |(req & group)));
        end
    end

    // vector requests gated by global enable; wake ignores it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_high_ff <= 1'b0;
            irq_low_ff  <= 1'b0;
            wake_ff     <= 1'b0;
        end else begin
            irq_high_ff <= nxt_high;
            irq_low_ff  <= nxt_low;
            wake_ff     <= core_sleeping && |req;
        end
    end

    // ------------------------------------------------------------
    // Context saving on interrupt entry
    // ------------------------------------------------------------
    // one-deep fast copy of working, status and bank registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_ctx_ff <= '0;
        end else if (irq_enter) begin
            fast_ctx_ff <= ctx_in;
        end
    end

    // return address pushed on the hardware stack
    pctl_ret_stack u_ret_stack (
        .pclk       (pclk),
        .presetn    (presetn),
        .push       (irq_enter),
        .push_data  (ret_pc),
        .pop        (ret_pop),
        .rd_data_ff (ret_pc_ff),
        .full_ff    (stack_full)
    );

endmodule // pctl_irq_ctrl

/* hdl/pctl_map.svh */
// Register offsets, field positions, reset values and constants of the irq controller
//
// Overview of operation
// - Legacy mode: peripherals need group enable too
// - Enable one: eight peripheral gates, reset zero
// - Enable two: five gates, top three read zero
// - Priority bits act only with levels enabled
// - Priority one: one is high, resets ones
// - Priority two: five bits, top zero, ones
// - Reset control bit seven enables priority levels
// - Reset control bits six, five zero; causes
// - External pins edge sensitive, edge selectable
// - Selected edge sets flag; enable gates request
// - Enabled external flag wakes sleeping processor
// - Vector after wake only with global enable
// - External one, two priority bits; zero high
// - Timer zero roll-over sets flag, both modes
// - Timer zero enable and priority bits
// - Port upper nibble change sets change flag
// - Entry pushes return address, saves context
// - Flags set regardless of any enable
`ifndef PCTL_MAP_SVH
`define PCTL_MAP_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define PCTL_OFF_EN_ONE    8'h00
`define PCTL_OFF_EN_TWO    8'h04
`define PCTL_OFF_PRIO_ONE  8'h08
`define PCTL_OFF_PRIO_TWO  8'h0c
`define PCTL_OFF_RST_CTL   8'h10
`define PCTL_OFF_MAIN_CTL  8'h14
`define PCTL_OFF_CTL_TWO   8'h18
`define PCTL_OFF_CTL_THREE 8'h1c
`define PCTL_OFF_TMR_MODE  8'h20
`define PCTL_OFF_STATUS    8'h24

// ------------------------------------------------------------
// Reset values and implemented-bit masks
// ------------------------------------------------------------
`define PCTL_RST_EN        8'h00
`define PCTL_RST_PRIO_ONE  8'hff
`define PCTL_RST_PRIO_TWO  8'h1f
`define PCTL_MASK_TWO      8'h1f
`define PCTL_RST_MAIN      8'h00
`define PCTL_RST_CTL_TWO   8'hf5
`define PCTL_MASK_CTL_TWO  8'hf5
`define PCTL_RST_CTL_THREE 8'hc0
`define PCTL_MASK_CTL_THR  8'hdb

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PCTL_RC_PRIO_LVL   7
`define PCTL_MC_GLOBAL     7
`define PCTL_MC_GROUP      6
`define PCTL_MC_T0_EN      5
`define PCTL_MC_X0_EN      4
`define PCTL_MC_PB_EN      3
`define PCTL_MC_T0_FLAG    2
`define PCTL_MC_X0_FLAG    1
`define PCTL_MC_PB_FLAG    0
`define PCTL_C2_EDGE0      6
`define PCTL_C2_EDGE1      5
`define PCTL_C2_EDGE2      4
`define PCTL_C2_T0_PRIO    2
`define PCTL_C2_PB_PRIO    0
`define PCTL_C3_X2_PRIO    7
`define PCTL_C3_X1_PRIO    6
`define PCTL_C3_X2_EN      4
`define PCTL_C3_X1_EN      3
`define PCTL_C3_X2_FLAG    1
`define PCTL_C3_X1_FLAG    0

// ------------------------------------------------------------
// Timer roll-over values and stack geometry
// ------------------------------------------------------------
`define PCTL_T0_MAX8       8'hff
`define PCTL_T0_MAX16      16'hffff
`define PCTL_STACK_DEPTH   8
`define PCTL_PC_W          16

`endif

/* hdl/pctl_pkg.sv */
// Types shared by the peripheral irq controller files
package pctl_pkg;

    // Context copied on interrupt entry
    typedef struct packed {
        logic [7:0] working_register;
        logic [7:0] status;
        logic [7:0] bank_select_register;
    } pctl_ctx_s;

    // Asynchronous pin group: port upper nibble and three external pins
    typedef struct packed {
        logic [3:0] port_b_hi;
        logic [2:0] ext_irq;
    } pctl_pins_s;

    // Bus slave phase, one-hot
    typedef enum logic [1:0] {
        PCTL_BUS_IDLE   = 2'b01,
        PCTL_BUS_ACCESS = 2'b10
    } pctl_bus_e;

endpackage

/* hdl/pctl_ret_stack.sv */
// Return address stack memory with registered read data
`timescale 1ns/1ps
`include "pctl_map.svh"

module pctl_ret_stack (
    // Clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // Push side
    input  wire logic                    push,
    input  wire logic [`PCTL_PC_W-1:0]   push_data,
    // Pop side
    input  wire logic                    pop,
    output logic      [`PCTL_PC_W-1:0]   rd_data_ff,
    output logic                         full_ff
);

    logic [`PCTL_PC_W-1:0] mem [`PCTL_STACK_DEPTH];
    logic [3:0]            depth_ff;

    // ------------------------------------------------------------
    // Storage; a push onto a full stack is dropped, not wrapped
    // ------------------------------------------------------------
    always_ff @(posedge pclk) begin
        if (push && (depth_ff < 4'(`PCTL_STACK_DEPTH))) begin
            mem[depth_ff[2:0]] <= push_data;
        end
    end

    // Occupancy count; pop has priority if both arrive together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            depth_ff <= 4'h0;
        end else if (pop && (depth_ff != 4'h0)) begin
            depth_ff <= depth_ff - 4'h1;
        end else if (push && (depth_ff < 4'(`PCTL_STACK_DEPTH))) begin
            depth_ff <= depth_ff + 4'h1;
        end
    end

    // Popped address is registered so the core sees a clean value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data_ff <= '0;
        end else if (pop && (depth_ff != 4'h0)) begin
            rd_data_ff <= mem[3'(depth_ff - 4'h1)];
        end
    end

    // Full indication for software visibility
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_ff <= 1'b0;
        end else begin
            full_ff <= (depth_ff == 4'(`PCTL_STACK_DEPTH));
        end
    end

endmodule // pctl_ret_stack

/* verif/pctl_core_model.sv */
// Core stand-in: enters on a request and returns one cycle later
`timescale 1ns/1ps
module pctl_core_model (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           irq_req,
    output logic                irq_enter,
    output logic                ret_pop,
    output logic [15:0]         ret_pc,
    output pctl_pkg::pctl_ctx_s ctx_in
);
    logic [3:0] step_ff;
    // context moves every cycle, so a stale capture shows at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {step_ff, irq_enter, ret_pop, ret_pc, ctx_in} <= '0;
        end else begin
            irq_enter <= irq_req && step_ff == 4'h0;
            ret_pop   <= step_ff == 4'h1;
            step_ff   <= step_ff + {3'h0, step_ff != 4'h0 || irq_req};
            ret_pc    <= ret_pc + 16'h0123;
            ctx_in    <= pctl_pkg::pctl_ctx_s'(ctx_in + 24'h010203);
        end
    end
endmodule // pctl_core_model

/* verif/pctl_irq_ctrl_monitor.sv */
// Port-level assertions for the peripheral irq controller
`timescale 1ns/1ps
module pctl_irq_ctrl_monitor (
    // Bus side
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [7:0]          paddr,
    input wire logic [31:0]         prdata_ff,
    input wire logic                pready_ff,
    input wire logic                pslverr_ff,
    // Core side
    input wire logic                irq_enter,
    input wire logic                ret_pop,
    input wire logic [15:0]         ret_pc,
    input wire pctl_pkg::pctl_ctx_s ctx_in,
    input wire pctl_pkg::pctl_ctx_s fast_ctx_ff,
    input wire logic [15:0]         ret_pc_ff
);
    // All checks share the bus clock and its reset
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_next: assert property (psel && !penable |=> pready_ff) else $error("no ready");
    a_ready_single: assert property (pready_ff |=> !pready_ff) else $error("ready too long");
    a_unmapped_err: assert property (psel && !penable && !pwrite && paddr[7:2] > 6'h09
        |=> pslverr_ff && prdata_ff == 32'h0) else $error("unmapped not refused");
    a_upper_zero: assert property (pready_ff |-> prdata_ff[31:8] == 24'h0) else $error("upper");
    a_two_reserved: assert property (pready_ff && !pwrite && paddr inside {8'h04, 8'h0c}
        |-> prdata_ff[7:5] == 3'h0) else $error("reserved bits set");
    a_gap_zero: assert property (pready_ff && !pwrite && paddr == 8'h10
        |-> prdata_ff[6:5] == 2'h0) else $error("gap bits set");
    a_ctx_capture: assert property (irq_enter |=> fast_ctx_ff == $past(ctx_in))
        else $error("context lost");
    a_ret_order: assert property (irq_enter ##1 (ret_pop && !irq_enter)
        |=> ret_pc_ff == $past(ret_pc, 2)) else $error("return address lost");
endmodule // pctl_irq_ctrl_monitor
bind pctl_irq_ctrl pctl_irq_ctrl_monitor i_mon (.*);

/* verif/pctl_irq_ctrl_test.sv */
// Self-checking bench for the peripheral irq controller
`timescale 1ns/1ps
module pctl_irq_ctrl_test;
    import pctl_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready_ff, pslverr_ff, sleep;
    logic        irq_enter, ret_pop, irq_high_ff, irq_low_ff, wake_ff;
    logic [7:0]  paddr, pf1;
    logic [15:0] tmr, ret_pc, ret_pc_ff;
    logic [31:0] pwdata, prdata_ff, seed, d, exp_q[$];
    logic [31:0] rst_v[11] = '{32'h0, 32'h0, 32'hff, 32'h1f, 32'h15, 32'h0, 32'hf5, 32'hc0,
                               32'h0, 32'h0, 32'h0};
    pctl_pins_s  pins;
    pctl_ctx_s   ctx_in, fast_ctx_ff;
    int          mismatches, num_checks;
    pctl_irq_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata_ff, .pready_ff, .pslverr_ff, .periph_flags_one(pf1), .periph_flags_two(pf1[4:0]),
        .reset_cause_flags(5'h15), .timer_zero_count(tmr), .pins, .core_sleeping(sleep),
        .irq_enter, .ret_pop, .ret_pc, .ctx_in, .irq_high_ff, .irq_low_ff, .wake_ff,
        .fast_ctx_ff, .ret_pc_ff);
    pctl_core_model i_core (.pclk, .presetn, .irq_req(irq_high_ff | irq_low_ff), .irq_enter,
        .ret_pop, .ret_pc, .ctx_in);
    // Free-running 250 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // One transfer; the edge wait at entry keeps back-to-back calls race free
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] wd);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready_ff !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic irq_is(logic [31:0] e, int n = 2);
        repeat (n) @(posedge pclk);
        check("irq", {30'h0, irq_high_ff, irq_low_ff}, e);
    endtask
    // Read data is compared at the edge where the master takes it
    always @(posedge pclk)
        if (psel && penable && pready_ff === 1'b1 && !pwrite)
            check("prdata", prdata_ff, exp_q.pop_front());
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Main sequence: registers, routing, then pin and timer events
    initial begin
        seed = 32'ha8261108;
        {psel, penable, pwrite, paddr, pwdata, pf1, tmr, pins, sleep} = '0;
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rst_v[i]) rd(8'(4 * i), rst_v[i]);
        for (int a = 0; a < 4; a++) begin
            d = $random(seed);
            apb(1'b1, 8'(4 * a), d);
            rd(8'(4 * a), d & (a[0] ? 32'h1f : 32'hff));
        end
        $display("register test done");
        apb(1'b1, 8'h00, 32'h40); // top bit kept clear
        apb(1'b1, 8'h08, 32'h80); // top bit kept set
        pf1 <= 8'h40;
        apb(1'b1, 8'h14, 32'h80);
        irq_is(32'h0);
        apb(1'b1, 8'h14, 32'hc0);
        irq_is(32'h2);
        apb(1'b1, 8'h10, 32'h80);
        irq_is(32'h1);
        apb(1'b1, 8'h08, 32'hc0);
        irq_is(32'h2);
        sleep <= 1'b1;
        irq_is(32'h2);
        check("wake", {31'h0, wake_ff}, 32'h1);
        {sleep, pf1} <= '0;
        apb(1'b1, 8'h14, 32'h00);
        $display("routing test done");
        pins <= '{port_b_hi: 4'h8, ext_irq: 3'h1};
        tmr <= 16'h00ff;
        @(posedge pclk);
        tmr <= 16'h0000;
        repeat (8) @(posedge pclk);
        rd(8'h14, 32'h07);
        apb(1'b1, 8'h14, 32'h92);
        irq_is(32'h2);
        apb(1'b1, 8'h14, 32'h80);
        apb(1'b1, 8'h14, 32'h90);
        irq_is(32'h0);
        apb(1'b1, 8'h18, 32'hb5);
        pins.ext_irq <= 3'h0;
        irq_is(32'h2, 8);
        $display("event test done");
        finish_test;
    end
    // Watchdog well beyond the expected run of about 130 cycles
    initial begin
        #20000;
        mismatches++;
        finish_test;
    end
endmodule // pctl_irq_ctrl_test
